// >>> verilog/rpsc_reset_pins.sv
// Reset phase sequencer driving every bus pin level through reset.
`timescale 1ns/1ps
`include "rpsc_cfg.svh"
module rpsc_reset_pins #(
	parameter logic [3:0] INIT_WRITES = `RPSC_INIT_WRITES,
	parameter logic [3:0] PREFETCH_CYCLES = `RPSC_PREFETCH_CYCLES
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Reset pins and straps.
	input wire logic system_reset_in_n,
	input wire rpsc_pkg::rpsc_bus_t boot_bus,
	// Pin groups.
	output rpsc_pkg::rpsc_mem_s mem_q,
	output rpsc_pkg::rpsc_pci_s pci_q,
	output rpsc_pkg::rpsc_isa_s isa_q,
	output rpsc_pkg::rpsc_ide_s ide_q,
	output logic system_reset_out_n_q,
	output logic boot_done_q
);
	import rpsc_pkg::*;

	//--------------------------------------------------------------------------
	// Phase sequencer
	//--------------------------------------------------------------------------
	rpsc_phase_e phase_q, phase_d; // Current reset phase.
	logic [3:0] cnt_q, cnt_d; // Cycle count within a boot phase.
	rpsc_bus_t bus_q, bus_d; // Strap captured at input release.

	// Phases only advance forward; a new input reset restarts from the top.
	always_comb begin
		phase_d = phase_q;
		cnt_d = cnt_q;
		bus_d = bus_q;
		if (!system_reset_in_n) begin
			phase_d = RPSC_IN_RST;
			cnt_d = 4'h0;
		end else begin
			case (phase_q)
				RPSC_IN_RST: begin
					// Straps are taken while the output reset still holds.
					bus_d = boot_bus;
					phase_d = RPSC_OUT_RST;
				end
				RPSC_OUT_RST: begin
					phase_d = RPSC_MEM_INIT;
					cnt_d = 4'h0;
				end
				RPSC_MEM_INIT: begin
					// Memory must be initialised before any prefetch.
					if (cnt_q == INIT_WRITES - 4'h1) begin
						phase_d = RPSC_PREFETCH;
						cnt_d = 4'h0;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				RPSC_PREFETCH: begin
					if (cnt_q == PREFETCH_CYCLES - 4'h1) begin
						phase_d = RPSC_RUN;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				RPSC_RUN: begin
					phase_d = RPSC_RUN;
				end
				default: begin
					phase_d = RPSC_IN_RST;
				end
			endcase
		end
	end

	// Phase registers.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			phase_q <= RPSC_IN_RST;
			cnt_q <= 4'h0;
			bus_q <= RPSC_BUS_ISA;
		end else begin
			phase_q <= phase_d;
			cnt_q <= cnt_d;
			bus_q <= bus_d;
		end
	end

	//--------------------------------------------------------------------------
	// Pin levels
	//--------------------------------------------------------------------------
	rpsc_mem_s mem_d; // Next memory pins.
	rpsc_pci_s pci_d; // Next PCI pins.
	rpsc_isa_s isa_d; // Next ISA/card/local pins.
	rpsc_ide_s ide_d; // Next IDE/video pins.
	logic in_rst; // Input reset phase.
	logic out_rst; // Output reset only phase.
	logic in_reset; // Either reset phase.
	logic init; // Memory init phase.
	logic pf; // Prefetch phase.

	// Pin levels are functions of the phase the sequencer will enter and the strapped bus.
	always_comb begin
		in_rst = phase_d == RPSC_IN_RST;
		out_rst = phase_d == RPSC_OUT_RST;
		in_reset = in_rst || out_rst;
		init = phase_d == RPSC_MEM_INIT;
		pf = phase_d == RPSC_PREFETCH;
		// Memory: idle strobes high, address zero, data released.
		mem_d.addr = `RPSC_MEM_ADDR_RST;
		mem_d.bank = 1'b0;
		mem_d.ras_n = 2'b11;
		mem_d.cas_n = 2'b11;
		mem_d.mem_write_enable_n = 1'b1;
		mem_d.dqm_n = 8'hFF;
		mem_d.data_oe = 1'b0;
		if (init) begin
			// Each init cycle is a write with all strobes active.
			mem_d.ras_n = 2'b00;
			mem_d.cas_n = 2'b00;
			mem_d.mem_write_enable_n = 1'b0;
			mem_d.dqm_n = 8'h00;
			mem_d.data_oe = 1'b1;
		end
		// PCI: address/data low, controls left as inputs, no grants.
		pci_d.ad = 32'h0000_0000;
		pci_d.ad_oe = in_reset;
		pci_d.cbe = 4'h0;
		pci_d.par = 1'b0;
		pci_d.ctrl_oe = 1'b0;
		pci_d.gnt_n = 3'h7;
		pci_d.prefetch = pf && (bus_q != RPSC_BUS_LOCAL);
		// ISA group.
		isa_d.isa_buffer_enable_n = in_reset;
		isa_d.sa = in_rst ? `RPSC_ISA_ADDR_IN_RST
			: `RPSC_ISA_ADDR_OUT_RST;
		isa_d.la = 7'h00;
		isa_d.sd = `RPSC_DATA_FF;
		isa_d.strobes_n = 1'b1;
		isa_d.ale = 1'b0;
		isa_d.aen = 1'b0;
		isa_d.encoded_dma_ack = in_reset ? 3'h0 : `RPSC_DMA_ACK_IDLE;
		isa_d.dack_oe = !in_reset;
		isa_d.tc = 1'b0;
		isa_d.gpio_chip_select_n = 1'b1;
		isa_d.gpio_cs_oe = !in_reset;
		isa_d.rtc_addr_strobe = 1'b0;
		// Card boot fetches go through the boot ROM select.
		isa_d.boot_rom_select_n =
			!(pf && bus_q == RPSC_BUS_PCMCIA);
		// Card pins: reset held high, power enables off, VPP low.
		isa_d.card_reset = in_reset;
		isa_d.card_enables_n = 1'b1;
		isa_d.prog_voltage_ctrl = 2'b00;
		// Local bus idle levels.
		isa_d.local_read_strobe_n = 1'b1;
		isa_d.local_write_strobe_n = 1'b1;
		isa_d.local_byte_enable_n = 2'b11;
		isa_d.flash_select0_n = 1'b1;
		isa_d.local_io_select_n = 8'hFF;
		// Boot address only leaves in prefetch when the strapped bus is not the local bus.
		isa_d.boot_addr = pf && bus_q != RPSC_BUS_LOCAL
			? `RPSC_BOOT_ADDR : 24'h000000;
		isa_d.prefetch = pf && bus_q != RPSC_BUS_LOCAL;
		// IDE and video.
		ide_d.dd = `RPSC_DATA_FF;
		ide_d.da = 3'h0;
		ide_d.cs = 4'h0;
		ide_d.dack_n = 2'b11;
		ide_d.io_n = 4'hF;
		ide_d.red = `RPSC_VIDEO_BLACK;
		ide_d.green = `RPSC_VIDEO_BLACK;
		ide_d.blue = `RPSC_VIDEO_BLACK;
	end

	// Pin registers; reset values match the input reset phase.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mem_q <= '{addr: 11'h000, bank: 1'b0, ras_n: 2'b11,
				cas_n: 2'b11, mem_write_enable_n: 1'b1,
				dqm_n: 8'hFF, data_oe: 1'b0};
			pci_q <= '{ad: 32'h0000_0000, ad_oe: 1'b1, cbe: 4'h0,
				par: 1'b0, ctrl_oe: 1'b0, gnt_n: 3'h7,
				prefetch: 1'b0};
			isa_q <= '0;
			isa_q.isa_buffer_enable_n <= 1'b1;
			isa_q.sa <= `RPSC_ISA_ADDR_IN_RST;
			isa_q.sd <= `RPSC_DATA_FF;
			isa_q.strobes_n <= 1'b1;
			isa_q.gpio_chip_select_n <= 1'b1;
			isa_q.boot_rom_select_n <= 1'b1;
			isa_q.card_reset <= 1'b1;
			isa_q.card_enables_n <= 1'b1;
			isa_q.local_read_strobe_n <= 1'b1;
			isa_q.local_write_strobe_n <= 1'b1;
			isa_q.local_byte_enable_n <= 2'b11;
			isa_q.flash_select0_n <= 1'b1;
			isa_q.local_io_select_n <= 8'hFF;
			ide_q <= '0;
			ide_q.dd <= `RPSC_DATA_FF;
			ide_q.dack_n <= 2'b11;
			ide_q.io_n <= 4'hF;
			system_reset_out_n_q <= 1'b0;
			boot_done_q <= 1'b0;
		end else begin
			mem_q <= mem_d;
			pci_q <= pci_d;
			isa_q <= isa_d;
			ide_q <= ide_d;
			system_reset_out_n_q <= !in_reset;
			boot_done_q <= phase_d == RPSC_RUN;
		end
	end
endmodule : rpsc_reset_pins

// >>> verilog/rpsc_cfg.svh
// Constants for the reset pin state controller: levels, addresses, timing.
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - Memory address and bank zero in input reset.
// - Memory strobes and masks high, data bus input.
// - After release, run memory init write cycles.
// - All three PCI grants held high in reset.
// - Not local bus: first prefetch on PCI.
// - ISA address FFFXX, then FFF03; upper zero.
// - ISA/PCMCIA prefetch starts at FFFFF0 on bus.
// - Second phase: ISA data FF, strobes high.
// - ALE/AEN low; DMA ack input, then 04.
// - PCMCIA: card reset high, enables high, VPP low.
// - Local bus: data FF, strobes and selects high.
// - IDE data FF, acks high, address low later.
// - Video outputs black throughout reset.
`ifndef RPSC_CFG_SVH
`define RPSC_CFG_SVH
`define RPSC_MEM_ADDR_RST 11'h000
`define RPSC_ISA_ADDR_IN_RST 20'hFFF00
`define RPSC_ISA_ADDR_OUT_RST 20'hFFF03
`define RPSC_BOOT_ADDR 24'hFFFFF0
`define RPSC_DATA_FF 16'h00FF
`define RPSC_DMA_ACK_IDLE 3'h4
`define RPSC_VIDEO_BLACK 8'h00
`define RPSC_INIT_WRITES 4'h8
`define RPSC_PREFETCH_CYCLES 4'h4
`endif

// >>> verilog/rpsc_pkg.sv
// Types shared by the reset pin state controller.
package rpsc_pkg;
	// Reset phase and boot activity, one-hot.
	typedef enum logic [4:0] {
		RPSC_IN_RST = 5'b00001,
		RPSC_OUT_RST = 5'b00010,
		RPSC_MEM_INIT = 5'b00100,
		RPSC_PREFETCH = 5'b01000,
		RPSC_RUN = 5'b10000
	} rpsc_phase_e;
	// Boot bus selection from the straps.
	typedef enum logic [1:0] {
		RPSC_BUS_ISA = 2'h0,
		RPSC_BUS_PCMCIA = 2'h1,
		RPSC_BUS_LOCAL = 2'h2
	} rpsc_bus_t;
	// SDRAM pins.
	typedef struct packed {
		logic [10:0] addr;
		logic bank;
		logic [1:0] ras_n;
		logic [1:0] cas_n;
		logic mem_write_enable_n;
		logic [7:0] dqm_n;
		logic data_oe;
	} rpsc_mem_s;
	// PCI pins.
	typedef struct packed {
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe;
		logic par;
		logic ctrl_oe;
		logic [2:0] gnt_n;
		logic prefetch;
	} rpsc_pci_s;
	// ISA / PCMCIA / local shared pins.
	typedef struct packed {
		logic isa_buffer_enable_n;
		logic [19:0] sa;
		logic [6:0] la;
		logic [15:0] sd;
		logic strobes_n;
		logic ale;
		logic aen;
		logic [2:0] encoded_dma_ack;
		logic dack_oe;
		logic tc;
		logic gpio_chip_select_n;
		logic gpio_cs_oe;
		logic rtc_addr_strobe;
		logic boot_rom_select_n;
		logic card_reset;
		logic card_enables_n;
		logic [1:0] prog_voltage_ctrl;
		logic local_read_strobe_n;
		logic local_write_strobe_n;
		logic [1:0] local_byte_enable_n;
		logic flash_select0_n;
		logic [7:0] local_io_select_n;
		logic [23:0] boot_addr;
		logic prefetch;
	} rpsc_isa_s;
	// IDE and video pins.
	typedef struct packed {
		logic [15:0] dd;
		logic [2:0] da;
		logic [3:0] cs;
		logic [1:0] dack_n;
		logic [3:0] io_n;
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} rpsc_ide_s;
endpackage : rpsc_pkg

// >>> tb/rpsc_far_model.sv
// Far-side model counting memory init writes and boot prefetch cycles.
`timescale 1ns/1ps
module rpsc_far_model (
	// Clock and output reset.
	input wire logic clock,
	input wire logic rst_out_n,
	// Observed pin groups.
	input wire rpsc_pkg::rpsc_mem_s mem,
	input wire rpsc_pkg::rpsc_pci_s pci,
	input wire rpsc_pkg::rpsc_isa_s isa,
	// Counts since the output reset was last low.
	output int n_wr,
	output int n_pf
);
	import rpsc_pkg::*;
	// The memory takes a write on each driven cycle with write enable low.
	always @(posedge clock) begin
		if (!rst_out_n) begin
			n_wr <= 0;
			n_pf <= 0;
		end else begin
			n_wr <= n_wr + int'(mem.data_oe && !mem.mem_write_enable_n);
			n_pf <= n_pf + int'(pci.prefetch || isa.prefetch);
		end
	end
endmodule : rpsc_far_model

// >>> tb/rpsc_reset_pins_monitor.sv
// Checker of pin levels through the reset phases.
`timescale 1ns/1ps
module rpsc_reset_pins_monitor #(
	parameter logic [3:0] INIT_WRITES = 4'h8,
	parameter logic [3:0] PREFETCH_CYCLES = 4'h4
) (
	// Clock, reset and straps.
	input wire logic clock,
	input wire logic nrst,
	input wire logic system_reset_in_n,
	input wire rpsc_pkg::rpsc_bus_t boot_bus,
	// Pin groups.
	input wire rpsc_pkg::rpsc_mem_s mem_q,
	input wire rpsc_pkg::rpsc_pci_s pci_q,
	input wire rpsc_pkg::rpsc_isa_s isa_q,
	input wire rpsc_pkg::rpsc_ide_s ide_q,
	input wire logic system_reset_out_n_q,
	input wire logic boot_done_q
);
	import rpsc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_MEM_ADDR: assert property (!system_reset_in_n |=>
		mem_q.addr == 11'h000 && !mem_q.bank) else $error("mem addr");
	AST_MEM_CTRL: assert property (!system_reset_in_n |=>
		&{mem_q.ras_n, mem_q.cas_n, mem_q.mem_write_enable_n, mem_q.dqm_n}
		&& !mem_q.data_oe) else $error("mem strobes");
	AST_PCI_IN: assert property (!system_reset_in_n |=>
		pci_q.ad == 32'h0 && !pci_q.ctrl_oe && pci_q.gnt_n == 3'h7)
		else $error("pci levels");
	AST_ISA_OE: assert property (isa_q.isa_buffer_enable_n ==
		!system_reset_out_n_q) else $error("isa buffer enable");
	AST_OUT_PHASE: assert property ($rose(system_reset_in_n)
		##1 system_reset_in_n |-> isa_q.sa == 20'hFFF03 && isa_q.la == 7'h00
		&& isa_q.sd == 16'h00FF && isa_q.strobes_n && !isa_q.rtc_addr_strobe
		&& !system_reset_out_n_q) else $error("output reset levels");
	AST_ISA_IN: assert property (!system_reset_in_n |=>
		!isa_q.ale && !isa_q.aen && !isa_q.dack_oe && !isa_q.gpio_cs_oe)
		else $error("isa reset levels");
	AST_ISA_RUN: assert property (system_reset_out_n_q |->
		isa_q.dack_oe && isa_q.encoded_dma_ack == 3'h4 && !isa_q.tc
		&& isa_q.gpio_cs_oe && isa_q.gpio_chip_select_n)
		else $error("isa run levels");
	AST_IDE_VGA: assert property (!system_reset_in_n |=>
		ide_q.dd == 16'h00FF && &ide_q.dack_n && &ide_q.io_n
		&& {ide_q.red, ide_q.green, ide_q.blue} == 24'h0)
		else $error("ide video levels");
	AST_INIT_START: assert property ($rose(system_reset_out_n_q) |->
		mem_q.data_oe && !mem_q.mem_write_enable_n) else $error("init");
	AST_BOOT_TIME: assert property ($rose(boot_done_q) |->
		$past(system_reset_out_n_q, INIT_WRITES + PREFETCH_CYCLES)
		&& !$past(system_reset_out_n_q, INIT_WRITES + PREFETCH_CYCLES + 1))
		else $error("boot done timing");
	AST_PREFETCH: assert property (isa_q.prefetch |->
		isa_q.boot_addr == 24'hFFFFF0 && boot_bus != RPSC_BUS_LOCAL)
		else $error("prefetch bus");
endmodule : rpsc_reset_pins_monitor
bind rpsc_reset_pins rpsc_reset_pins_monitor #(.INIT_WRITES(INIT_WRITES),
	.PREFETCH_CYCLES(PREFETCH_CYCLES)) i_mon (.clock(clock), .nrst(nrst),
	.system_reset_in_n(system_reset_in_n), .boot_bus(boot_bus),
	.mem_q(mem_q), .pci_q(pci_q), .isa_q(isa_q), .ide_q(ide_q),
	.system_reset_out_n_q(system_reset_out_n_q), .boot_done_q(boot_done_q));

// >>> tb/tb_top.sv
// Testbench walking the reset phases for every boot bus.
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top;
	import rpsc_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic rin_n = 1'b0;
	rpsc_bus_t bus = RPSC_BUS_ISA;
	rpsc_mem_s mem;
	rpsc_pci_s pci;
	rpsc_isa_s isa;
	rpsc_ide_s ide;
	logic rout_n;
	logic done;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int n_wr;
	int n_pf;
	rpsc_reset_pins i_dut (.clock(clock), .nrst(nrst),
		.system_reset_in_n(rin_n), .boot_bus(bus), .mem_q(mem), .pci_q(pci),
		.isa_q(isa), .ide_q(ide), .system_reset_out_n_q(rout_n),
		.boot_done_q(done));
	rpsc_far_model i_far (.clock(clock), .rst_out_n(rout_n), .mem(mem),
		.pci(pci), .isa(isa), .n_wr(n_wr), .n_pf(n_pf));
	always #50 clock = ~clock;
	// A hang is cut short well beyond the few dozen cycles needed.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task end_sim;
		if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Input reset held: every group shows its first-phase levels.
	task in_reset_levels;
		rin_n = 1'b0;
		@(negedge clock);
		`CHK("addr", 11'h000, mem.addr)
		`CHK("ras", 2'h3, mem.ras_n)
		`CHK("dq oe", 1'b0, mem.data_oe)
		`CHK("cbe par", 5'h00, {pci.cbe, pci.par})
		`CHK("gnt", 3'h7, pci.gnt_n)
		`CHK("isa_buffer_enable_n", 1'b1, isa.isa_buffer_enable_n)
		`CHK("dack oe", 1'b0, isa.dack_oe)
		`CHK("gpio oe", 1'b0, isa.gpio_cs_oe)
		`CHK("local", 1'b1, isa.local_write_strobe_n)
		`CHK("ide dd", 16'h00FF, ide.dd)
		`CHK("video", 8'h00, ide.green)
	endtask : in_reset_levels
	// Release with the given boot bus and follow the run to boot done.
	task boot_run(input rpsc_bus_t b);
		bus = b;
		@(negedge clock);
		rin_n = 1'b1;
		@(negedge clock);
		`CHK("sa", 20'hFFF03, isa.sa)
		`CHK("sd", 16'h00FF, isa.sd)
		`CHK("rout", 1'b0, rout_n)
		`CHK("card", 2'h3, {isa.card_reset, isa.card_enables_n})
		`CHK("vpp", 2'h0, isa.prog_voltage_ctrl)
		`CHK("prd", 1'b1, isa.local_read_strobe_n)
		`CHK("ide da", 3'h0, ide.da)
		@(negedge clock);
		`CHK("rout", 1'b1, rout_n)
		`CHK("isa_buffer_enable_n", 1'b0, isa.isa_buffer_enable_n)
		`CHK("dack", 3'h4, isa.encoded_dma_ack)
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge clock);
			if (isa.prefetch)
				`CHK("rom", b != RPSC_BUS_PCMCIA, isa.boot_rom_select_n)
		end
		`CHK("done", 1'b1, done)
		`CHK("writes", 8, n_wr)
		`CHK("prefetch", b == RPSC_BUS_LOCAL ? 0 : 4, n_pf)
	endtask : boot_run
	// Input reset reasserted in mid-init throws the block back to phase one.
	task abort_mid;
		rin_n = 1'b0;
		@(negedge clock);
		rin_n = 1'b1;
		repeat (4) @(negedge clock);
		`CHK("init oe", 1'b1, mem.data_oe)
		rin_n = 1'b0;
		@(negedge clock);
		`CHK("rout", 1'b0, rout_n)
		`CHK("dq oe", 1'b0, mem.data_oe)
		`CHK("done", 1'b0, done)
	endtask : abort_mid
	initial begin
		repeat (6) @(negedge clock);
		nrst = 1'b1;
		in_reset_levels();
		boot_run(RPSC_BUS_ISA);
		in_reset_levels();
		boot_run(RPSC_BUS_PCMCIA);
		abort_mid();
		boot_run(RPSC_BUS_LOCAL);
		in_reset_levels();
		end_sim();
	end
endmodule : tb_top
